// ---- core/power_ctl_defs.vh ----
// Purpose: Shared constants for the power-state and reset controller.
// Assumes: Included by bare name from every design file of the block.
// Notes: The poll time is given in ms and turned into a clock count here; the other windows are given in cycles.
`ifndef POWER_CTL_DEFS_VH
`define POWER_CTL_DEFS_VH

// Reference clock rate in kHz.
`define REF_CLK_KHZ 25000
// Sensor polling interval in ms and the derived cycle count.
`define POLL_INTERVAL_MS 35
`define POLL_CYCLES (`POLL_INTERVAL_MS * `REF_CLK_KHZ)
// Glitch window of the reset pin in reference clock cycles.
`define RST_FILT_CYCLES 16
// Cycles after entry to deep sleep before the alert pin is watched.
`define ALERT_SETTLE_CYCLES 4

// Register offsets.
`define CTL_ADDR 8'h00
`define STATUS_ADDR 8'h02
`define STATE_ADDR 8'h03
`define SLIDER_ADDR 8'h06

// Control register fields and reset value.
`define CTL_SLEEP_BIT 0
`define CTL_DEACTIVATE_CTL_BIT 1
`define CTL_DDOZE_BIT 2
`define CTL_STBY_LO 3
`define CTL_STBY_HI 4
`define CTL_RESET_VAL 5'h00

// Status register fields.
`define STAT_RESET_BIT 0
`define STAT_TOUCH_BIT 1

// Reset value of the slider position register.
`define SLIDER_RESET_VAL 8'h00

// Standby lamp modes for indicator_eleven.
`define STBY_OFF 2'h0
`define STBY_ON 2'h1
`define STBY_FOLLOW 2'h2
`define STBY_IDLE 2'h3

// Power state codes.
`define PST_ACTIVE 2'h0
`define PST_SLEEP 2'h1
`define PST_DEEP 2'h2
`define PST_INACT 2'h3

// Channel counts.
`define NUM_SENSORS 14
`define NUM_LAMPS 11
`define SLEEP_MASK_DEF 14'h0003

`endif

// ---- core/reset_glitch_filter.v ----
// Purpose: Synchronise the active-high reset pin and reject short glitches.
// Assumes: The pin is asynchronous to i_ref_clk.
// Notes: The filtered level follows only after FILT_CYCLES of a stable new level.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.vh"

module reset_glitch_filter #(
    parameter FILT_CYCLES = `RST_FILT_CYCLES
) (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_pin,
    output reg o_level
);

    reg sync1_q;
    reg sync2_q;
    reg sync3_q;
    reg [15:0] cnt_q;

    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A new level counts once two stages agree and it has lasted the window.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            cnt_q <= 16'h0000;
            o_level <= 1'b0;
        end else if ((sync2_q != sync3_q) || (sync3_q == o_level)) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q >= FILT_CYCLES[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            o_level <= sync3_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule // reset_glitch_filter

`default_nettype wire

// ---- core/power_state_reset_control.v ----
// Purpose: Decode power states, gate sensing, bus and lamps, handle reset pin.
// Assumes: Register strobes come from the serial port logic on i_ref_clk.
// Notes: The alert pin is open drain; it is released in deep sleep and watched.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.vh"

module power_state_reset_control #(
    parameter POLL_CYCLES = `POLL_CYCLES,
    parameter RST_FILT_CYCLES = `RST_FILT_CYCLES,
    parameter [`NUM_SENSORS-1:0] SLEEP_MASK = `SLEEP_MASK_DEF
) (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_reset_pin,
    input wire i_alert_in,
    output reg o_alert_out,
    output reg o_alert_oe_n,
    input wire i_bus_hit,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    input wire [`NUM_SENSORS-1:0] i_sensor_en,
    input wire i_touch_irq,
    input wire i_slider_upd,
    input wire [7:0] i_slider_val,
    input wire [`NUM_LAMPS-1:0] i_lamp_drive,
    input wire [`NUM_LAMPS-1:0] i_lamp_idle,
    output reg [`NUM_LAMPS-1:0] o_lamp,
    output reg [`NUM_LAMPS-1:0] o_lamp_pwm_en,
    output reg [`NUM_SENSORS-1:0] o_scan_mask,
    output reg o_poll_tick,
    output reg o_bus_en,
    output reg o_blocks_reset,
    output reg o_clear_touch,
    output reg [`NUM_SENSORS-1:0] o_clear_mask,
    output reg [1:0] o_power_state
);

    localparam [1:0] ST_ACTIVE = `PST_ACTIVE;
    localparam [1:0] ST_SLEEP = `PST_SLEEP;
    localparam [1:0] ST_DEEP = `PST_DEEP;
    localparam [1:0] ST_INACT = `PST_INACT;

    wire pin_rst;
    reg pin_rst_q;
    reg [4:0] ctl_q;
    reg [1:0] stat_q;
    reg [7:0] slider_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`NUM_SENSORS-1:0] mask_d;
    reg [31:0] poll_cnt_q;
    reg [2:0] settle_q;
    reg al_s1_q;
    reg al_s2_q;
    reg al_s3_q;
    reg alert_lvl_q;
    reg wake;
    wire [1:0] stby_mode;
    wire enter_deep;
    wire ctl_hit;
    wire stat_hit;
    wire slider_hit;

    assign stby_mode = ctl_q[`CTL_STBY_HI:`CTL_STBY_LO];
    assign ctl_hit = (i_reg_addr == `CTL_ADDR);
    assign stat_hit = (i_reg_addr == `STATUS_ADDR);
    assign slider_hit = (i_reg_addr == `SLIDER_ADDR);
    assign enter_deep = (state_d == ST_DEEP) && (state_q != ST_DEEP);

    reset_glitch_filter #(
        .FILT_CYCLES(RST_FILT_CYCLES)
    ) u_reset_filter (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_reset_pin),
        .o_level(pin_rst)
    );

    // Alert pin synchroniser; the level is taken when stages two and three agree.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            al_s1_q <= 1'b1;
            al_s2_q <= 1'b1;
            al_s3_q <= 1'b1;
            alert_lvl_q <= 1'b1;
        end else begin
            al_s1_q <= i_alert_in;
            al_s2_q <= al_s1_q;
            al_s3_q <= al_s2_q;
            if (al_s2_q == al_s3_q) begin
                alert_lvl_q <= al_s3_q;
            end
        end
    end

    // Settle time lets the released alert line return high before it is watched.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || state_q != ST_DEEP) begin
            settle_q <= 3'h0;
        end else if (settle_q != `ALERT_SETTLE_CYCLES) begin
            settle_q <= settle_q + 3'h1;
        end
    end

    // Wake from deep sleep by an active-low alert or a bus access to us.
    always @* begin
        wake = 1'b0;
        if (state_q == ST_DEEP && !pin_rst && ctl_q[`CTL_DDOZE_BIT]) begin
            if (settle_q == `ALERT_SETTLE_CYCLES && !alert_lvl_q) begin
                wake = 1'b1;
            end else if (i_bus_hit) begin
                wake = 1'b1;
            end
        end
    end

    // Next power state from the control bits with their priority.
    always @* begin
        if (pin_rst || ctl_q[`CTL_DDOZE_BIT]) begin
            state_d = ST_DEEP;
        end else if (ctl_q[`CTL_DEACTIVATE_CTL_BIT]) begin
            state_d = ST_INACT;
        end else if (ctl_q[`CTL_SLEEP_BIT]) begin
            state_d = ST_SLEEP;
        end else begin
            state_d = ST_ACTIVE;
        end
    end

    // Channels scanned in the next state.
    always @* begin
        case (state_d)
            ST_ACTIVE: begin
                mask_d = i_sensor_en;
            end
            ST_SLEEP: begin
                mask_d = i_sensor_en & SLEEP_MASK;
            end
            default: begin
                mask_d = {`NUM_SENSORS{1'b0}};
            end
        endcase
    end

    // Control register; the hardware clears deep doze on wake.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || pin_rst) begin
            ctl_q <= `CTL_RESET_VAL;
        end else if (wake) begin
            ctl_q[`CTL_DDOZE_BIT] <= 1'b0;
        end else if (i_reg_wr && ctl_hit && state_q != ST_DEEP) begin
            ctl_q <= i_reg_wdata[4:0];
        end
    end

    // Status flags are set by events and cleared by writing one; a set wins.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || pin_rst) begin
            stat_q <= 2'h0;
        end else begin
            if (pin_rst_q) begin
                stat_q[`STAT_RESET_BIT] <= 1'b1;
            end else if (i_reg_wr && stat_hit && i_reg_wdata[`STAT_RESET_BIT]) begin
                stat_q[`STAT_RESET_BIT] <= 1'b0;
            end
            if (i_touch_irq && (state_q == ST_ACTIVE || state_q == ST_SLEEP)) begin
                stat_q[`STAT_TOUCH_BIT] <= 1'b1;
            end else if (i_reg_wr && stat_hit && i_reg_wdata[`STAT_TOUCH_BIT]) begin
                stat_q[`STAT_TOUCH_BIT] <= 1'b0;
            end
        end
    end

    // Slider position register, cleared when deep sleep is entered.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || pin_rst) begin
            slider_q <= `SLIDER_RESET_VAL;
        end else if (enter_deep) begin
            slider_q <= `SLIDER_RESET_VAL;
        end else if (i_reg_wr && slider_hit && state_q != ST_DEEP) begin
            slider_q <= i_reg_wdata;
        end else if (i_slider_upd && state_q != ST_DEEP) begin
            slider_q <= i_slider_val;
        end
    end

    // Power state, scan mask and clearing of touches on state changes.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_ACTIVE;
            pin_rst_q <= 1'b0;
            o_scan_mask <= {`NUM_SENSORS{1'b0}};
            o_clear_touch <= 1'b0;
            o_clear_mask <= {`NUM_SENSORS{1'b0}};
            o_power_state <= ST_ACTIVE;
            o_blocks_reset <= 1'b0;
        end else begin
            state_q <= state_d;
            pin_rst_q <= pin_rst;
            o_scan_mask <= mask_d;
            o_power_state <= state_d;
            o_blocks_reset <= pin_rst;
            o_clear_touch <= (state_d != state_q);
            if (state_d != state_q) begin
                o_clear_mask <= o_scan_mask & ~mask_d;
            end else begin
                o_clear_mask <= {`NUM_SENSORS{1'b0}};
            end
        end
    end

    // Polling tick while any channel is scanned.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || pin_rst) begin
            poll_cnt_q <= 32'h00000000;
            o_poll_tick <= 1'b0;
        end else if (mask_d == {`NUM_SENSORS{1'b0}}) begin
            poll_cnt_q <= 32'h00000000;
            o_poll_tick <= 1'b0;
        end else if (poll_cnt_q >= POLL_CYCLES - 1) begin
            poll_cnt_q <= 32'h00000000;
            o_poll_tick <= 1'b1;
        end else begin
            poll_cnt_q <= poll_cnt_q + 32'h00000001;
            o_poll_tick <= 1'b0;
        end
    end

    // Bus port enable and alert pin drive.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_bus_en <= 1'b1;
            o_alert_out <= 1'b0;
            o_alert_oe_n <= 1'b1;
        end else begin
            o_bus_en <= (state_d != ST_DEEP);
            o_alert_out <= 1'b0;
            if (state_d == ST_DEEP) begin
                o_alert_oe_n <= 1'b1;
            end else begin
                o_alert_oe_n <= ~(|stat_q);
            end
        end
    end

    // Lamp gating for all lamps but indicator_eleven.
    genvar g;
    generate
        for (g = 0; g < `NUM_LAMPS - 1; g = g + 1) begin : g_lamp
            always @(posedge i_ref_clk) begin
                if (!i_reset_n) begin
                    o_lamp[g] <= 1'b0;
                    o_lamp_pwm_en[g] <= 1'b0;
                end else begin
                    case (state_d)
                        ST_ACTIVE, ST_SLEEP: begin
                            o_lamp[g] <= i_lamp_drive[g];
                            o_lamp_pwm_en[g] <= 1'b1;
                        end
                        ST_DEEP: begin
                            o_lamp[g] <= i_lamp_idle[g];
                            o_lamp_pwm_en[g] <= 1'b0;
                        end
                        default: begin
                            o_lamp[g] <= 1'b0;
                            o_lamp_pwm_en[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // indicator_eleven follows its standby setting in sleep states.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_lamp[`NUM_LAMPS-1] <= 1'b0;
            o_lamp_pwm_en[`NUM_LAMPS-1] <= 1'b0;
        end else begin
            case (state_d)
                ST_ACTIVE: begin
                    o_lamp[`NUM_LAMPS-1] <= i_lamp_drive[`NUM_LAMPS-1];
                    o_lamp_pwm_en[`NUM_LAMPS-1] <= 1'b1;
                end
                ST_SLEEP, ST_DEEP: begin
                    o_lamp_pwm_en[`NUM_LAMPS-1] <= (stby_mode == `STBY_FOLLOW);
                    case (stby_mode)
                        `STBY_OFF: begin
                            o_lamp[`NUM_LAMPS-1] <= 1'b0;
                        end
                        `STBY_ON: begin
                            o_lamp[`NUM_LAMPS-1] <= 1'b1;
                        end
                        `STBY_FOLLOW: begin
                            o_lamp[`NUM_LAMPS-1] <= i_lamp_drive[`NUM_LAMPS-1];
                        end
                        default: begin
                            o_lamp[`NUM_LAMPS-1] <= i_lamp_idle[`NUM_LAMPS-1];
                        end
                    endcase
                end
                default: begin
                    o_lamp[`NUM_LAMPS-1] <= 1'b0;
                    o_lamp_pwm_en[`NUM_LAMPS-1] <= 1'b0;
                end
            endcase
        end
    end

    // Register read data, one cycle after the strobe.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n || pin_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (ctl_hit) begin
                o_reg_rdata <= {3'h0, ctl_q};
            end else if (stat_hit) begin
                o_reg_rdata <= {6'h00, stat_q};
            end else if (i_reg_addr == `STATE_ADDR) begin
                o_reg_rdata <= {6'h00, state_q};
            end else if (slider_hit) begin
                o_reg_rdata <= slider_q;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

endmodule // power_state_reset_control

`default_nettype wire

// ---- sim/power_state_reset_control_monitor.sv ----
// Purpose: Concurrent checks on the ports of the power-state and reset controller.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Attached by the bind statement after the module.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.vh"
module power_state_reset_control_monitor #(
    parameter POLL_CYCLES = `POLL_CYCLES,
    parameter RST_FILT_CYCLES = `RST_FILT_CYCLES,
    parameter [`NUM_SENSORS-1:0] SLEEP_MASK = `SLEEP_MASK_DEF
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_reset_pin,
    input wire logic i_bus_hit,
    input wire logic [`NUM_LAMPS-1:0] i_lamp_idle,
    input wire logic o_alert_oe_n,
    input wire logic [`NUM_LAMPS-1:0] o_lamp,
    input wire logic [`NUM_LAMPS-1:0] o_lamp_pwm_en,
    input wire logic [`NUM_SENSORS-1:0] o_scan_mask,
    input wire logic o_poll_tick,
    input wire logic o_bus_en,
    input wire logic o_blocks_reset,
    input wire logic o_clear_touch,
    input wire logic [1:0] o_power_state
);
    default clocking mon_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    int gap_q;
    int hi_q;
    int lo_q;
    int deep_q;
    logic seen_q;
    // Counts gaps between poll ticks, pin level runs and cycles spent in deep sleep.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            hi_q <= 0;
            lo_q <= 0;
            deep_q <= 0;
        end else begin
            hi_q <= i_reset_pin ? hi_q + 1 : 0;
            lo_q <= i_reset_pin ? 0 : lo_q + 1;
            deep_q <= (o_power_state == `PST_DEEP) ? deep_q + 1 : 0;
        end
        if (!i_reset_n || o_scan_mask == '0 || o_scan_mask != $past(o_scan_mask)) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else if (o_poll_tick) begin
            gap_q <= 1;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 1;
        end
    end
    chk_deep_bus_off: assert property (o_power_state == `PST_DEEP |-> !o_bus_en)
        else $error("bus enabled in deep sleep");
    chk_deep_alert_rel: assert property (o_power_state == `PST_DEEP |-> o_alert_oe_n)
        else $error("alert driven in deep sleep");
    chk_inact_dark: assert property (
        o_power_state == `PST_INACT |-> o_lamp == '0 && o_scan_mask == '0)
        else $error("lamps or scanning active while inactive");
    chk_deep_lamp_idle: assert property (
        o_power_state == `PST_DEEP && $past(o_power_state) == `PST_DEEP
        |-> ((o_lamp ^ $past(i_lamp_idle)) & 11'h3FF) == '0 && (o_lamp_pwm_en & 11'h3FF) == '0)
        else $error("lamps not idle in deep sleep");
    chk_state_clears: assert property ($changed(o_power_state) |-> o_clear_touch)
        else $error("no touch clear on state change");
    chk_poll_gap: assert property (o_poll_tick && seen_q |-> gap_q == POLL_CYCLES)
        else $error("poll tick spacing wrong");
    chk_sleep_scan: assert property (
        o_power_state == `PST_SLEEP |-> (o_scan_mask & ~SLEEP_MASK) == '0)
        else $error("sleep scans channels outside its set");
    chk_bus_wake: assert property (deep_q >= 6 && i_bus_hit && !o_blocks_reset
        |-> ##[1:3] o_power_state != `PST_DEEP)
        else $error("bus traffic did not wake deep sleep");
    chk_pin_hold: assert property (o_blocks_reset && $past(o_blocks_reset)
        |-> o_power_state == `PST_DEEP && !o_bus_en)
        else $error("held reset pin did not keep deep sleep");
    chk_filter_rise: assert property (
        $rose(o_blocks_reset) |-> hi_q >= RST_FILT_CYCLES)
        else $error("reset pin acted before the glitch window");
    chk_filter_fall: assert property (
        $fell(o_blocks_reset) |-> lo_q >= RST_FILT_CYCLES)
        else $error("reset pin release acted before the glitch window");
    chk_restart_alert: assert property (
        $fell(o_blocks_reset) |-> ##[1:6] !o_alert_oe_n)
        else $error("no alert after reset pin release");
endmodule // power_state_reset_control_monitor
bind power_state_reset_control power_state_reset_control_monitor #(
    .POLL_CYCLES(POLL_CYCLES),
    .RST_FILT_CYCLES(RST_FILT_CYCLES),
    .SLEEP_MASK(SLEEP_MASK)
) u_monitor (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_reset_pin(i_reset_pin),
    .i_bus_hit(i_bus_hit),
    .i_lamp_idle(i_lamp_idle),
    .o_alert_oe_n(o_alert_oe_n),
    .o_lamp(o_lamp),
    .o_lamp_pwm_en(o_lamp_pwm_en),
    .o_scan_mask(o_scan_mask),
    .o_poll_tick(o_poll_tick),
    .o_bus_en(o_bus_en),
    .o_blocks_reset(o_blocks_reset),
    .o_clear_touch(o_clear_touch),
    .o_power_state(o_power_state)
);
`default_nettype wire

// ---- sim/host_alert_model.sv ----
// Purpose: Host side of the shared open-drain alert line.
// Assumes: The line has a pull-up and the device drives only low.
// Notes: A wake request holds the line low long enough to pass the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module host_alert_model (
    input wire logic i_ref_clk,
    input wire logic i_dut_out,
    input wire logic i_dut_oe_n,
    input wire logic i_wake_req,
    output logic o_alert_wire
);
    int hold_q = 0;
    // Pulls the line to its active low level to wake the device.
    always @(posedge i_ref_clk) begin
        if (i_wake_req) begin
            hold_q <= 12;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    // The line is low while any party drives it, otherwise pulled high.
    assign o_alert_wire = (!i_dut_oe_n && !i_dut_out) || hold_q != 0 ? 1'b0 : 1'b1;
endmodule // host_alert_model
`default_nettype wire

// ---- sim/power_state_reset_control_tb.sv ----
// Purpose: Self-checking bench for the power-state and reset controller.
// Assumes: Inputs change at the falling clock edge.
// Notes: Short poll interval so that tick spacing is seen quickly.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.vh"
module power_state_reset_control_tb;
    localparam int POLL = 50;
    localparam int FILT = 16;
    localparam logic [10:0] DRIVE = 11'h5A5;
    localparam logic [10:0] IDLE = 11'h0F0;
    logic clk, rst_n, pin, hit, wr, rd, touch, supd, wake;
    logic [7:0] addr, wdata, sval, rdata;
    logic [13:0] sen, smask, cmask;
    logic [10:0] lamp, pwm, drv;
    logic alert_wire, alert_out, oe_n, tick, bus_en, blk, clr;
    logic [1:0] pst;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    power_state_reset_control #(.POLL_CYCLES(POLL), .RST_FILT_CYCLES(FILT)) dut (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_reset_pin(pin), .i_alert_in(alert_wire),
        .o_alert_out(alert_out), .o_alert_oe_n(oe_n), .i_bus_hit(hit), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_sensor_en(sen), .i_touch_irq(touch), .i_slider_upd(supd), .i_slider_val(sval),
        .i_lamp_drive(drv), .i_lamp_idle(IDLE), .o_lamp(lamp), .o_lamp_pwm_en(pwm),
        .o_scan_mask(smask), .o_poll_tick(tick), .o_bus_en(bus_en), .o_blocks_reset(blk),
        .o_clear_touch(clr), .o_clear_mask(cmask), .o_power_state(pst));
    host_alert_model partner (.i_ref_clk(clk), .i_dut_out(alert_out), .i_dut_oe_n(oe_n),
        .i_wake_req(wake), .o_alert_wire(alert_wire));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    task automatic t_states();
        logic [7:0] v;
        logic l10;
        reg_rd(8'h7F, v);
        check("unmapped read", v, 8'h00);
        drv = 11'h000;
        reg_wr(8'h00, 8'h02);
        @(negedge clk);
        check("clear pulse", clr, 1'b1);
        check("clear mask", cmask, 14'h3FFF);
        idle(2);
        check("inactive state", pst, `PST_INACT);
        check("inactive lamps", lamp, 11'h000);
        check("inactive scan", smask, 14'h0000);
        check("inactive bus", bus_en, 1'b1);
        drv = DRIVE;
        reg_wr(8'h00, 8'h03);
        idle(3);
        check("deactivate over sleep", pst, `PST_INACT);
        check("deactivate lamps", lamp, 11'h000);
        for (int s = 0; s < 4; s++) begin
            reg_wr(8'h00, {3'h0, s[1:0], 3'h1});
            idle(3);
            l10 = (s == 0) ? 1'b0 : (s == 1) ? 1'b1 : (s == 2) ? DRIVE[10] : IDLE[10];
            check("sleep state", pst, `PST_SLEEP);
            check("sleep lamps", lamp, {l10, DRIVE[9:0]});
            check("sleep scan", smask, `SLEEP_MASK_DEF);
        end
        reg_wr(8'h00, 8'h00);
        idle(3);
        check("active state", pst, `PST_ACTIVE);
        check("active lamps", lamp, DRIVE);
        $display("test states done");
    endtask
    task automatic t_deep_bus();
        logic [7:0] v;
        @(negedge clk);
        supd = 1'b1;
        touch = 1'b1;
        sval = 8'h3C;
        @(negedge clk);
        supd = 1'b0;
        touch = 1'b0;
        reg_rd(8'h06, v);
        check("slider update", v, 8'h3C);
        check("touch alert", oe_n, 1'b0);
        reg_wr(8'h00, 8'h05);
        idle(3);
        check("deep state", pst, `PST_DEEP);
        check("deep bus", bus_en, 1'b0);
        check("deep alert", oe_n, 1'b1);
        check("deep lamps", lamp, {1'b0, IDLE[9:0]});
        check("deep pwm", pwm[9:0], 10'h000);
        check("deep scan", smask, 14'h0000);
        reg_wr(8'h00, 8'h00);
        idle(8);
        check("deep write ignored", pst, `PST_DEEP);
        hit = 1'b1;
        @(negedge clk);
        hit = 1'b0;
        idle(3);
        check("bus wake state", pst, `PST_SLEEP);
        reg_rd(8'h00, v);
        check("doze bit cleared", v, 8'h01);
        reg_rd(8'h06, v);
        check("slider cleared", v, 8'h00);
        $display("test deep bus wake done");
    endtask
    task automatic t_alert_wake();
        logic [7:0] v;
        int n;
        reg_wr(8'h00, 8'h14);
        idle(3);
        check("deep indicator", lamp[10], DRIVE[10]);
        idle(8);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        n = 0;
        while (pst === `PST_DEEP && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("alert wake state", pst, `PST_ACTIVE);
        reg_rd(8'h00, v);
        check("alert wake ctl", v, 8'h10);
        $display("test alert wake done");
    endtask
    task automatic t_reset_pin();
        logic [7:0] v;
        logic seen;
        reg_wr(8'h00, 8'h18);
        pin = 1'b1;
        idle(FILT / 2);
        pin = 1'b0;
        seen = 1'b0;
        repeat (30) begin
            @(negedge clk);
            if (blk !== 1'b0) seen = 1'b1;
        end
        check("glitch ignored", seen, 1'b0);
        pin = 1'b1;
        idle(FILT + 20);
        check("pin reset", blk, 1'b1);
        check("pin deep", pst, `PST_DEEP);
        check("pin bus", bus_en, 1'b0);
        pin = 1'b0;
        idle(FILT + 20);
        check("pin release", blk, 1'b0);
        reg_rd(8'h00, v);
        check("ctl default", v, 8'h00);
        reg_rd(8'h02, v);
        check("reset flag", v, 8'h01);
        check("reset alert", oe_n, 1'b0);
        check("alert data", alert_out, 1'b0);
        reg_wr(8'h02, 8'h01);
        idle(2);
        check("alert released", oe_n, 1'b1);
        touch = 1'b1;
        @(negedge clk);
        touch = 1'b0;
        reg_rd(8'h02, v);
        check("touch flag", v, 8'h02);
        $display("test reset pin done");
    endtask
    task automatic t_poll();
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("poll gap", n, POLL);
        $display("test poll done");
    endtask
    initial begin
        {pin, hit, wr, rd, touch, supd, wake} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        sval = 8'h00;
        sen = 14'h3FFF;
        drv = DRIVE;
        rst_n = 1'b0;
        idle(3);
        rst_n = 1'b1;
        t_states();
        t_deep_bus();
        t_alert_wake();
        t_reset_pin();
        t_poll();
        summarize();
    end
endmodule // power_state_reset_control_tb
`default_nettype wire
